// [rtl/msac_ctrl.sv]
// Purpose: master-side sequencer that configures a motor drive and runs its auto setup
// Assumes: device object entry port with held request and one-cycle ack
// Notes:   one access in flight at a time
//
// Functional notes
// - Every entry is reached by a 16-bit index and 8-bit subindex.
// - Static address written to entries, then static bit disables DHCP.
// - Master writes pole pair count into 2030h:00h.
// - Submode 3202h: 41h selects BLDC, bit 3 stepper current reduction.
// - Brake: 0Ch stepper with brake and reduction, 44h BLDC with brake.
// - Encoder config 2059h codes 0 to 3 for supply and signalling.
// - BLDC 203Bh:01h rated mA, 203Bh:02h peak duration ms, start 100.
// - 2031h:00h in mA: stepper rated, BLDC peak current.
// - Program execution must be stopped, 2300h bit 0 zero, before start.
// - Write FEh to 6060h, enable operation, set controlword bit 4.
`timescale 1ns/1ps
`default_nettype none
`include "msac_defines.svh"

module msac_ctrl #(
  parameter logic [15:0] POLL_LIMIT = `MSAC_POLL_LIMIT
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic        STATIC_IP_EN,
  input  wire logic [31:0] STATIC_IP,
  input  wire logic [31:0] STATIC_MASK,
  input  wire logic        MOTOR_BLDC,
  input  wire logic        HAS_BRAKE,
  input  wire logic        CUR_REDUCE,
  input  wire logic        HAS_ENCODER,
  input  wire logic [1:0]  ENC_CODE,
  input  wire logic [31:0] POLE_PAIRS,
  input  wire logic [31:0] MAX_CURRENT_MA,
  input  wire logic [31:0] RATED_MA,
  input  wire logic [31:0] PEAK_MS,
  output logic             BUSY,
  output logic             DONE,
  output logic             FAIL,
  output logic             PROG_RUNNING,
  output logic             INDEX_FOUND,
  output logic             CLOSED_LOOP_OK,
  output logic             OD_REQ,
  output logic             OD_WR,
  output logic [15:0]      OD_INDEX,
  output logic [7:0]       OD_SUB,
  output logic [31:0]      OD_WDATA,
  input  wire logic        OD_ACK,
  input  wire logic        OD_ERR,
  input  wire logic [31:0] OD_RDATA
);

  msac_pkg::msac_state_t state_q, state_d;
  msac_pkg::msac_step_t  step_q,  step_d;
  logic [15:0]           poll_q,  poll_d;
  logic                  done_q,  done_d;
  logic                  fail_q,  fail_d;
  logic                  prun_q,  prun_d;
  logic                  idxf_q,  idxf_d;
  logic                  clok_q,  clok_d;

  logic                  s_wr;
  logic                  s_skip;
  logic [15:0]           s_idx;
  logic [7:0]            s_sub;
  logic [31:0]           s_data;
  logic                  x_go;
  logic                  x_done;
  logic                  x_err;
  logic [31:0]           x_rdata;
  logic [31:0]           submode;

  // ----------------------------------------------------------------
  // motor drive submode code
  // ----------------------------------------------------------------
  always_comb
  begin
    if (MOTOR_BLDC)
      submode = HAS_BRAKE ? `MSAC_SUB_BLDC_BRAKE : `MSAC_SUB_BLDC;
    else if (HAS_BRAKE)
      submode = `MSAC_SUB_STEP_BRAKE;
    else
      submode = CUR_REDUCE ? `MSAC_SUB_STEP_CURRED : `MSAC_SUB_STEP_PLAIN;
  end

  // ----------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------
  always_comb
  begin
    s_wr   = 1'b1;
    s_skip = 1'b0;
    s_idx  = `MSAC_IDX_CTRLWORD;
    s_sub  = `MSAC_SUB_00;
    s_data = `MSAC_CW_OP_ENABLE;
    unique case (step_q)
      `MSAC_ST_IP_ADDR:
      begin
        s_idx  = `MSAC_IDX_IP_ADDR;
        s_data = STATIC_IP;
        s_skip = !STATIC_IP_EN;
      end
      `MSAC_ST_IP_MASK:
      begin
        s_idx  = `MSAC_IDX_IP_MASK;
        s_data = STATIC_MASK;
        s_skip = !STATIC_IP_EN;
      end
      `MSAC_ST_IP_CFG:
      begin
        s_idx  = `MSAC_IDX_IP_CFG;
        s_data = STATIC_IP_EN ? `MSAC_IP_STATIC : `MSAC_IP_DHCP;
      end
      `MSAC_ST_POLES:
      begin
        s_idx  = `MSAC_IDX_POLE_PAIRS;
        s_data = POLE_PAIRS;
      end
      `MSAC_ST_MAXCUR:
      begin
        s_idx  = `MSAC_IDX_MAX_CURRENT;
        s_data = MAX_CURRENT_MA;
      end
      `MSAC_ST_RATED:
      begin
        s_idx  = `MSAC_IDX_BLDC_CUR;
        s_sub  = `MSAC_SUB_01;
        s_data = RATED_MA;
        s_skip = !MOTOR_BLDC;
      end
      `MSAC_ST_PEAK_MS:
      begin
        s_idx  = `MSAC_IDX_BLDC_CUR;
        s_sub  = `MSAC_SUB_02;
        s_data = PEAK_MS;
        s_skip = !MOTOR_BLDC;
      end
      `MSAC_ST_SUBMODE:
      begin
        s_idx  = `MSAC_IDX_SUBMODE;
        s_data = submode;
      end
      `MSAC_ST_ENC:
      begin
        s_idx  = `MSAC_IDX_ENC_CFG;
        s_data = {30'h00000000, ENC_CODE};
        s_skip = !HAS_ENCODER;
      end
      `MSAC_ST_PROG_CHK:
      begin
        s_wr   = 1'b0;
        s_idx  = `MSAC_IDX_PROG_CTRL;
        s_data = 32'h00000000;
      end
      `MSAC_ST_MODE:
      begin
        s_idx  = `MSAC_IDX_OP_MODE;
        s_data = `MSAC_MODE_AUTOSETUP;
      end
      `MSAC_ST_CW_SHUT:  s_data = `MSAC_CW_SHUTDOWN;
      `MSAC_ST_CW_ON:    s_data = `MSAC_CW_SWITCH_ON;
      `MSAC_ST_CW_EN:    s_data = `MSAC_CW_OP_ENABLE;
      `MSAC_ST_CW_START: s_data = `MSAC_CW_START;
      `MSAC_ST_POLL:
      begin
        s_wr   = 1'b0;
        s_idx  = `MSAC_IDX_STATWORD;
        s_data = 32'h00000000;
      end
      `MSAC_ST_CW_STOP:  s_data = `MSAC_CW_OP_ENABLE;
      default:           s_skip = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    step_d  = step_q;
    poll_d  = poll_q;
    done_d  = done_q;
    fail_d  = fail_q;
    prun_d  = prun_q;
    idxf_d  = idxf_q;
    clok_d  = clok_q;
    x_go    = 1'b0;
    unique case (state_q)
      msac_pkg::MSAC_IDLE:
      begin
        if (START)
        begin
          state_d = msac_pkg::MSAC_ISSUE;
          step_d  = `MSAC_ST_IP_ADDR;
          poll_d  = 16'h0000;
          done_d  = 1'b0;
          fail_d  = 1'b0;
          prun_d  = 1'b0;
          idxf_d  = 1'b0;
          clok_d  = 1'b0;
        end
      end
      msac_pkg::MSAC_ISSUE:
      begin
        if (s_skip)
          step_d = step_q + 5'h01;
        else
        begin
          x_go    = 1'b1;
          state_d = msac_pkg::MSAC_WAIT;
        end
      end
      msac_pkg::MSAC_WAIT:
      begin
        if (x_done)
        begin
          state_d = msac_pkg::MSAC_ISSUE;
          step_d  = step_q + 5'h01;
          if (x_err)
          begin
            state_d = msac_pkg::MSAC_IDLE;
            fail_d  = 1'b1;
            done_d  = 1'b1;
          end
          else if (step_q == `MSAC_ST_PROG_CHK && x_rdata[`MSAC_PROG_RUN_BIT])
          begin
            state_d = msac_pkg::MSAC_IDLE;
            prun_d  = 1'b1;
            fail_d  = 1'b1;
            done_d  = 1'b1;
          end
          else if (step_q == `MSAC_ST_POLL && !x_rdata[`MSAC_SW_DONE_BIT])
          begin
            step_d = step_q;
            poll_d = poll_q + 16'h0001;
            if (poll_q == POLL_LIMIT)
            begin
              state_d = msac_pkg::MSAC_IDLE;
              fail_d  = 1'b1;
              done_d  = 1'b1;
            end
          end
          else if (step_q == `MSAC_ST_POLL)
            idxf_d = x_rdata[`MSAC_SW_INDEX_BIT];
          else if (step_q == `MSAC_ST_LAST)
          begin
            state_d = msac_pkg::MSAC_IDLE;
            done_d  = 1'b1;
            clok_d  = 1'b1;
          end
        end
      end
      default:
        state_d = msac_pkg::MSAC_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= msac_pkg::MSAC_IDLE;
      step_q  <= 5'h00;
      poll_q  <= 16'h0000;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
      prun_q  <= 1'b0;
      idxf_q  <= 1'b0;
      clok_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      step_q  <= step_d;
      poll_q  <= poll_d;
      done_q  <= done_d;
      fail_q  <= fail_d;
      prun_q  <= prun_d;
      idxf_q  <= idxf_d;
      clok_q  <= clok_d;
    end
  end

  msac_xfer u_xfer (
    .clk      (CLK),
    .rst      (RST),
    .go       (x_go),
    .wr       (s_wr),
    .index    (s_idx),
    .sub      (s_sub),
    .wdata    (s_data),
    .od_req   (OD_REQ),
    .od_wr    (OD_WR),
    .od_index (OD_INDEX),
    .od_sub   (OD_SUB),
    .od_wdata (OD_WDATA),
    .od_ack   (OD_ACK),
    .od_err   (OD_ERR),
    .od_rdata (OD_RDATA),
    .done     (x_done),
    .err      (x_err),
    .rdata    (x_rdata)
  );

  assign BUSY           = (state_q != msac_pkg::MSAC_IDLE);
  assign DONE           = done_q;
  assign FAIL           = fail_q;
  assign PROG_RUNNING   = prun_q;
  assign INDEX_FOUND    = idxf_q;
  assign CLOSED_LOOP_OK = clok_q;

endmodule : msac_ctrl

`default_nettype wire

// [rtl/msac_defines.svh]
// Purpose: constants of the motor setup and auto-tune controller
// Assumes: object entries are 32-bit words addressed by 16-bit index and 8-bit subindex
// Notes:   definitions only
`ifndef MSAC_DEFINES_SVH
`define MSAC_DEFINES_SVH

// ----------------------------------------------------------------
// object entry indexes and subindexes
// ----------------------------------------------------------------
`define MSAC_IDX_IP_CFG      16'h2010
`define MSAC_IDX_IP_ADDR     16'h2011
`define MSAC_IDX_IP_MASK     16'h2012
`define MSAC_IDX_POLE_PAIRS  16'h2030
`define MSAC_IDX_MAX_CURRENT 16'h2031
`define MSAC_IDX_BLDC_CUR    16'h203B
`define MSAC_IDX_ENC_CFG     16'h2059
`define MSAC_IDX_PROG_CTRL   16'h2300
`define MSAC_IDX_SUBMODE     16'h3202
`define MSAC_IDX_CTRLWORD    16'h6040
`define MSAC_IDX_STATWORD    16'h6041
`define MSAC_IDX_OP_MODE     16'h6060
`define MSAC_SUB_00          8'h00
`define MSAC_SUB_01          8'h01
`define MSAC_SUB_02          8'h02

// ----------------------------------------------------------------
// values written
// ----------------------------------------------------------------
`define MSAC_IP_STATIC       32'h00000001
`define MSAC_IP_DHCP         32'h00000000
`define MSAC_SUB_STEP_PLAIN  32'h00000000
`define MSAC_SUB_STEP_CURRED 32'h00000008
`define MSAC_SUB_STEP_BRAKE  32'h0000000C
`define MSAC_SUB_BLDC        32'h00000041
`define MSAC_SUB_BLDC_BRAKE  32'h00000044
`define MSAC_MODE_AUTOSETUP  32'h000000FE
`define MSAC_CW_SHUTDOWN     32'h00000006
`define MSAC_CW_SWITCH_ON    32'h00000007
`define MSAC_CW_OP_ENABLE    32'h0000000F
`define MSAC_CW_START        32'h0000001F

// ----------------------------------------------------------------
// bit positions in read words
// ----------------------------------------------------------------
`define MSAC_PROG_RUN_BIT    0
`define MSAC_SW_DONE_BIT     12
`define MSAC_SW_INDEX_BIT    10

// ----------------------------------------------------------------
// sequence steps and counts
// ----------------------------------------------------------------
`define MSAC_ST_IP_ADDR      5'h00
`define MSAC_ST_IP_MASK      5'h01
`define MSAC_ST_IP_CFG       5'h02
`define MSAC_ST_POLES        5'h03
`define MSAC_ST_MAXCUR       5'h04
`define MSAC_ST_RATED        5'h05
`define MSAC_ST_PEAK_MS      5'h06
`define MSAC_ST_SUBMODE      5'h07
`define MSAC_ST_ENC          5'h08
`define MSAC_ST_PROG_CHK     5'h09
`define MSAC_ST_MODE         5'h0A
`define MSAC_ST_CW_SHUT      5'h0B
`define MSAC_ST_CW_ON        5'h0C
`define MSAC_ST_CW_EN        5'h0D
`define MSAC_ST_CW_START     5'h0E
`define MSAC_ST_POLL         5'h0F
`define MSAC_ST_CW_STOP      5'h10
`define MSAC_ST_LAST         5'h10
`define MSAC_POLL_LIMIT      16'hFFFF

`endif

// [rtl/msac_pkg.sv]
// Purpose: types of the motor setup and auto-tune controller
// Assumes: constants live in msac_defines.svh
// Notes:   nothing is imported by users
package msac_pkg;

  typedef enum logic [1:0] {
    MSAC_IDLE  = 2'b00,
    MSAC_ISSUE = 2'b01,
    MSAC_WAIT  = 2'b10
  } msac_state_t;

  typedef logic [4:0] msac_step_t;

endpackage : msac_pkg

// [rtl/msac_xfer.sv]
// Purpose: one object entry access toward the device
// Assumes: device answers each held request with a one-cycle ack
// Notes:   request outputs and read data come from flip-flops
`timescale 1ns/1ps
`default_nettype none

module msac_xfer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [15:0] index,
  input  wire logic [7:0]  sub,
  input  wire logic [31:0] wdata,
  output logic             od_req,
  output logic             od_wr,
  output logic [15:0]      od_index,
  output logic [7:0]       od_sub,
  output logic [31:0]      od_wdata,
  input  wire logic        od_ack,
  input  wire logic        od_err,
  input  wire logic [31:0] od_rdata,
  output logic             done,
  output logic             err,
  output logic [31:0]      rdata
);

  logic        req_q,   req_d;
  logic        wr_q,    wr_d;
  logic [15:0] idx_q,   idx_d;
  logic [7:0]  sub_q,   sub_d;
  logic [31:0] wdat_q,  wdat_d;
  logic [31:0] rdat_q,  rdat_d;
  logic        done_q,  done_d;
  logic        err_q,   err_d;

  // ----------------------------------------------------------------
  // request hold and answer capture
  // ----------------------------------------------------------------
  always_comb
  begin
    req_d  = req_q;
    wr_d   = wr_q;
    idx_d  = idx_q;
    sub_d  = sub_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    err_d  = err_q;
    done_d = 1'b0;
    if (!req_q && go)
    begin
      req_d  = 1'b1;
      wr_d   = wr;
      idx_d  = index;
      sub_d  = sub;
      wdat_d = wdata;
    end
    else if (req_q && od_ack)
    begin
      req_d  = 1'b0;
      rdat_d = od_rdata;
      err_d  = od_err;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_q  <= 1'b0;
      wr_q   <= 1'b0;
      idx_q  <= 16'h0000;
      sub_q  <= 8'h00;
      wdat_q <= 32'h00000000;
      rdat_q <= 32'h00000000;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end
    else
    begin
      req_q  <= req_d;
      wr_q   <= wr_d;
      idx_q  <= idx_d;
      sub_q  <= sub_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
      err_q  <= err_d;
    end
  end

  assign od_req   = req_q;
  assign od_wr    = wr_q;
  assign od_index = idx_q;
  assign od_sub   = sub_q;
  assign od_wdata = wdat_q;
  assign done     = done_q;
  assign err      = err_q;
  assign rdata    = rdat_q;

endmodule : msac_xfer

`default_nettype wire

// [bench/msac_ctrl_props.sv]
// Purpose: concurrent checks on the ports of msac_ctrl
// Assumes: one clock domain, RST synchronous active high
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "msac_defines.svh"

module msac_ctrl_props #(
  parameter logic [15:0] POLL_LIMIT = 16'h0004
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        START,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        FAIL,
  input wire logic        PROG_RUNNING,
  input wire logic        INDEX_FOUND,
  input wire logic        CLOSED_LOOP_OK,
  input wire logic        OD_REQ,
  input wire logic        OD_WR,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0]  OD_SUB,
  input wire logic [31:0] OD_WDATA,
  input wire logic        OD_ACK,
  input wire logic        OD_ERR,
  input wire logic [31:0] OD_RDATA
);
  // ----------------------------------------
  // status read counter per run
  // ----------------------------------------
  logic [15:0] poll_q;
  logic [15:0] poll_d;
  logic        stat_rd;

  assign stat_rd = OD_REQ && OD_ACK && !OD_WR && (OD_INDEX == `MSAC_IDX_STATWORD);

  always_comb
  begin
    poll_d = poll_q;
    if (START && !BUSY)
      poll_d = 16'h0000;
    else if (stat_rd)
      poll_d = poll_q + 16'h0001;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      poll_q <= 16'h0000;
    else
      poll_q <= poll_d;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_ack;
    OD_REQ && OD_ACK;
  endsequence

  sequence s_end_fail;
    ##[1:4] (DONE && FAIL && !BUSY && !CLOSED_LOOP_OK);
  endsequence

  chk_req_hold: assert property (OD_REQ && !OD_ACK |=> OD_REQ && $stable(OD_WR)
    && $stable(OD_INDEX) && $stable(OD_SUB) && $stable(OD_WDATA))
    else $error("request changed before answer");
  chk_req_gap: assert property (s_ack |=> !OD_REQ [*2])
    else $error("request not spaced after answer");
  chk_start_clear: assert property (START && !BUSY |=> BUSY && !DONE && !FAIL
    && !CLOSED_LOOP_OK && !INDEX_FOUND)
    else $error("start did not clear status");
  chk_err_abort: assert property (s_ack ##0 OD_ERR |-> s_end_fail)
    else $error("error answer did not end run");
  chk_prog_abort: assert property (s_ack ##0 (!OD_WR && OD_RDATA[0]
    && OD_INDEX == `MSAC_IDX_PROG_CTRL) |-> s_end_fail ##0 PROG_RUNNING)
    else $error("running program did not abort run");
  chk_loop_grant: assert property (CLOSED_LOOP_OK |-> DONE && !FAIL && !BUSY)
    else $error("closed loop granted without success");
  chk_index_found: assert property (stat_rd && OD_RDATA[12] && OD_RDATA[10]
    |-> ##[1:40] (DONE && INDEX_FOUND))
    else $error("index flag not reported");
  chk_index_none: assert property (stat_rd && OD_RDATA[12] && !OD_RDATA[10]
    |-> ##[1:40] (DONE && !INDEX_FOUND && CLOSED_LOOP_OK))
    else $error("index flag wrongly reported");
  chk_poll_bound: assert property (OD_REQ && !OD_WR
    && OD_INDEX == `MSAC_IDX_STATWORD |-> poll_q <= POLL_LIMIT)
    else $error("too many status polls");
  chk_req_busy: assert property (OD_REQ |-> BUSY)
    else $error("request while idle");
  chk_done_idle: assert property ($rose(DONE) |-> !BUSY && !OD_REQ)
    else $error("done while still active");
endmodule : msac_ctrl_props

bind msac_ctrl msac_ctrl_props #(.POLL_LIMIT(POLL_LIMIT)) u_msac_ctrl_props (
  .CLK(CLK), .RST(RST), .START(START), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL),
  .PROG_RUNNING(PROG_RUNNING), .INDEX_FOUND(INDEX_FOUND), .CLOSED_LOOP_OK(CLOSED_LOOP_OK),
  .OD_REQ(OD_REQ), .OD_WR(OD_WR), .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB),
  .OD_WDATA(OD_WDATA), .OD_ACK(OD_ACK), .OD_ERR(OD_ERR), .OD_RDATA(OD_RDATA));
`default_nettype wire

// [bench/msac_dev_model.sv]
// Purpose: behavioural drive object store answering entry accesses
// Assumes: held request, one-cycle answer after dly wait cycles
// Notes:   writes are logged for the bench
`timescale 1ns/1ps
`default_nettype none

module msac_dev_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [15:0] index,
  input  wire logic [7:0]  sub,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic             err,
  output logic [31:0]      rdata,
  input  wire logic [1:0]  dly,
  input  wire logic        prog_run,
  input  wire logic        idx_fnd,
  input  wire logic [3:0]  need,
  input  wire logic [15:0] err_idx
);
  logic [2:0]  cnt_q;
  logic [3:0]  polls_q;
  logic        fin;
  logic [55:0] wlog[$];

  assign fin = (polls_q >= need);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack     <= 1'b0;
      err     <= 1'b0;
      rdata   <= 32'hA5C3_5A3C;
      cnt_q   <= 3'h0;
      polls_q <= 4'h0;
    end
    else if (ack)
    begin
      ack   <= 1'b0;
      err   <= 1'b0;
      rdata <= ~rdata;
    end
    else if (req && cnt_q < {1'b0, dly})
      cnt_q <= cnt_q + 3'h1;
    else if (req)
    begin
      cnt_q <= 3'h0;
      ack   <= 1'b1;
      // error answer chosen by index alone; subindex is ignored
      err   <= (index == err_idx);
      rdata <= 32'h0000_0000;
      if (wr)
      begin
        wlog.push_back({index, sub, wdata});
        // address config takes only static bit 0
        if (index == 16'h2010 && wdata[31:1] != 31'h0000_0000)
          err <= 1'b1;
        // cyclic data and limit switches lie off this path
        if (index == 16'h6040 && wdata[4])
          polls_q <= 4'h0;
      end
      else if (index == 16'h2300)
        rdata <= {31'h0000_0000, prog_run};
      else if (index == 16'h6041)
      begin
        rdata   <= {19'h0_0000, fin, 1'b0, fin & idx_fnd, 10'h000};
        polls_q <= fin ? polls_q : polls_q + 4'h1;
      end
    end
  end
endmodule : msac_dev_model
`default_nettype wire

// [bench/test_msac_ctrl.sv]
// Purpose: self-checking bench of msac_ctrl against a drive model
// Assumes: POLL_LIMIT shortened to 4
// Notes:   expected write log built from the bench settings
`timescale 1ns/1ps
`default_nettype none

module test_msac_ctrl;
  localparam logic [31:0] IP = 32'hC0A8_0264;
  localparam logic [31:0] MASK = 32'hFFFF_FF00;
  localparam logic [31:0] CUR = 32'h0000_0BB8;
  localparam logic [31:0] RATED = 32'h0000_07D0;
  localparam logic [31:0] PEAK = 32'h0000_0064;
  logic        clk, rst, start, sip, bldc, brake, red, has_enc, prog_run, idx_fnd;
  logic [1:0]  enc, dly;
  logic [3:0]  need;
  logic [15:0] err_idx;
  logic [31:0] poles;
  logic        busy, done, fail, prun, ifound, clok, req, wr, ack, oerr;
  logic [15:0] index;
  logic [7:0]  sub;
  logic [31:0] wdata, rdata;
  logic [55:0] exp_q[$];
  logic [2:0]  cfg[5] = '{3'b110, 3'b100, 3'b010, 3'b001, 3'b000};
  int          error_cnt, checks;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  msac_ctrl #(.POLL_LIMIT(16'h0004)) u_msac_ctrl (.CLK(clk), .RST(rst), .START(start),
    .STATIC_IP_EN(sip), .STATIC_IP(IP), .STATIC_MASK(MASK), .MOTOR_BLDC(bldc),
    .HAS_BRAKE(brake), .CUR_REDUCE(red), .HAS_ENCODER(has_enc), .ENC_CODE(enc),
    .POLE_PAIRS(poles), .MAX_CURRENT_MA(CUR), .RATED_MA(RATED), .PEAK_MS(PEAK),
    .BUSY(busy), .DONE(done), .FAIL(fail), .PROG_RUNNING(prun), .INDEX_FOUND(ifound),
    .CLOSED_LOOP_OK(clok), .OD_REQ(req), .OD_WR(wr), .OD_INDEX(index), .OD_SUB(sub),
    .OD_WDATA(wdata), .OD_ACK(ack), .OD_ERR(oerr), .OD_RDATA(rdata));

  msac_dev_model u_msac_dev_model (.clk(clk), .rst(rst), .req(req), .wr(wr),
    .index(index), .sub(sub), .wdata(wdata), .ack(ack), .err(oerr), .rdata(rdata),
    .dly(dly), .prog_run(prog_run), .idx_fnd(idx_fnd), .need(need), .err_idx(err_idx));

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_flag

  task automatic cmp_entry(input string nm, input logic [55:0] e, input logic [55:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_entry

  task automatic conclude;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // expected writes; stage 0 error, 1 abort, 2 timeout, 3 success
  // ----------------------------------------
  task automatic put(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    exp_q.push_back({i, s, d});
  endtask : put

  task automatic build(input int stage);
    exp_q.delete();
    if (sip)
    begin
      put(16'h2011, 8'h00, IP);
      put(16'h2012, 8'h00, MASK);
    end
    put(16'h2010, 8'h00, {31'h0000_0000, sip});
    put(16'h2030, 8'h00, poles);
    if (stage == 0) return;
    put(16'h2031, 8'h00, CUR);
    if (bldc)
    begin
      put(16'h203B, 8'h01, RATED);
      put(16'h203B, 8'h02, PEAK);
    end
    put(16'h3202, 8'h00, bldc ? (brake ? 32'h0000_0044 : 32'h0000_0041)
      : (brake ? 32'h0000_000C : (red ? 32'h0000_0008 : 32'h0000_0000)));
    if (has_enc) put(16'h2059, 8'h00, {30'h0000_0000, enc});
    if (stage == 1) return;
    put(16'h6060, 8'h00, 32'h0000_00FE);
    put(16'h6040, 8'h00, 32'h0000_0006);
    put(16'h6040, 8'h00, 32'h0000_0007);
    put(16'h6040, 8'h00, 32'h0000_000F);
    put(16'h6040, 8'h00, 32'h0000_001F);
    if (stage == 3) put(16'h6040, 8'h00, 32'h0000_000F);
  endtask : build

  task automatic go(input int stage, input logic f);
    int n;
    @(posedge clk);
    start <= 1'b1;
    build(stage);
    u_msac_dev_model.wlog.delete();
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4000)
    begin
      error_cnt++;
      conclude();
    end
    cmp_flag("fail", f, fail);
    cmp_flag("closed_loop", !f, clok);
    cmp_flag("busy", 1'b0, busy);
    cmp_entry("log size", 56'(exp_q.size()), 56'(u_msac_dev_model.wlog.size()));
    foreach (exp_q[k])
      if (k < u_msac_dev_model.wlog.size())
        cmp_entry("log entry", exp_q[k], u_msac_dev_model.wlog[k]);
  endtask : go

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    {sip, bldc, brake, red, has_enc, prog_run, idx_fnd} = 7'h00;
    enc = 2'h0;
    dly = 2'h0;
    need = 4'h0;
    err_idx = 16'h0000;
    poles = 32'h0000_0032;
    error_cnt = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp_flag("reset request", 1'b0, req);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      {bldc, brake, red} <= cfg[i];
      sip <= i[0];
      has_enc <= (i < 4);
      enc <= i[1:0];
      dly <= i[1:0];
      idx_fnd <= i[0];
      need <= (i == 4) ? 4'h4 : i[3:0];
      poles <= i[0] ? 32'h0000_0064 : 32'h0000_0032;
      go(3, 1'b0);
      cmp_flag("index_found", i[0], ifound);
    end
    @(posedge clk);
    err_idx <= 16'h2030;
    go(0, 1'b1);
    @(posedge clk);
    err_idx <= 16'h0000;
    prog_run <= 1'b1;
    go(1, 1'b1);
    cmp_flag("prog_running", 1'b1, prun);
    @(posedge clk);
    prog_run <= 1'b0;
    need <= 4'h5;
    go(2, 1'b1);
    @(posedge clk);
    need <= 4'h1;
    go(3, 1'b0);
    conclude();
  end
endmodule : test_msac_ctrl
`default_nettype wire
